/* File: verilog/paged_pkg.sv */
/*
 * Shared constants and carrier types for the paged data space address
 * generator: page selector widths, address widths and request structs.
 * Assumes a core that issues 16-bit data space byte addresses.
 */
package paged_pkg;

    // Core data address and page selector widths.
    localparam int DATA_ADDR_W = 16;
    localparam int PAGE_W      = 10;
    localparam int WIN_OFS_W   = 15;
    // Paged address: page number above the 32-Kbyte window offset.
    localparam int PAGED_W     = PAGE_W + WIN_OFS_W;

    // Bit of the core address that selects the paged upper half.
    localparam int UPPER_BIT = 15;

    // Window size in bytes, 32 Kbytes.
    localparam int WINDOW_BYTES = 32768;

    // Read page values at or above this reach program space.
    localparam logic [PAGE_W-1:0] PROG_PAGE_BASE = 10'h200;

    // Extended data space span, 16 Mbytes; program space view, 8 Mbytes.
    localparam int EXT_DATA_BYTES = 16777216;
    localparam int PROG_VIEW_BYTES = 8388608;

    // Page selector reset values.
    localparam logic [PAGE_W-1:0] READ_PAGE_RST  = 10'h001;
    localparam logic [PAGE_W-1:0] WRITE_PAGE_RST = 10'h001;

    // Target of an access after address generation.
    typedef enum logic [1:0] {
        TGT_BASE_DATA = 2'b00,
        TGT_EXT_DATA  = 2'b01,
        TGT_PROG      = 2'b10,
        TGT_NONE      = 2'b11
    } target_t;

    // Access request from the core load/store path.
    typedef struct packed {
        logic                   valid;
        logic                   write;
        logic [DATA_ADDR_W-1:0] addr;
    } core_req_t;

    // Generated access toward the memory system.
    typedef struct packed {
        logic                   valid;
        logic                   write;
        target_t                target;
        logic [PAGED_W-1:0]     addr;
    } mem_req_t;

endpackage : paged_pkg

/* File: verilog/page_map.sv */
/*
 * Combinational address map for one access: picks the page selector by
 * direction and builds the target and full paged address.
 * Assumes page selector values that are already registered upstream.
 */
`timescale 1ns/1ps

module page_map (
    input  wire paged_pkg::core_req_t               req,
    input  wire logic [paged_pkg::PAGE_W-1:0]       read_page_select,
    input  wire logic [paged_pkg::PAGE_W-1:0]       write_page_select,
    output paged_pkg::mem_req_t                     mapped
);

    logic [paged_pkg::PAGE_W-1:0] page;

    // Direction picks the selector; writes never use the read page.
    always_comb begin
        page = req.write ? write_page_select : read_page_select;
        mapped.valid  = req.valid;
        mapped.write  = req.write;
        mapped.addr   = {page, req.addr[paged_pkg::WIN_OFS_W-1:0]};
        mapped.target = paged_pkg::TGT_EXT_DATA;
        if (!req.addr[paged_pkg::UPPER_BIT]) begin
            // Lower half is the base space; page plays no part.
            mapped.addr   = {{paged_pkg::PAGE_W{1'b0}},
                             req.addr[paged_pkg::WIN_OFS_W-1:0]};
            mapped.target = paged_pkg::TGT_BASE_DATA;
        end else if (!req.write &&
                     page >= paged_pkg::PROG_PAGE_BASE) begin
            mapped.target = paged_pkg::TGT_PROG;
        end else if (req.write &&
                     page >= paged_pkg::PROG_PAGE_BASE) begin
            // A write page in the program range has nowhere to land.
            mapped.target = paged_pkg::TGT_NONE;
            mapped.valid  = 1'b0;
        end
    end

endmodule : page_map

/* File: verilog/paged_data_space_address_gen.sv */
/*
 * Paged address generator between the core load/store path and memory.
 * Holds the read and write page selectors, loaded by the core, and
 * registers each mapped access for one cycle.
 * Assumes the core presents one access per cycle, synchronous to ref_clk.
 */
// Notes on behaviour
// - Upper half of data space is a 32-Kbyte window into paged memory.
// - Paged address is page selector joined with core's upper-half offset.
// - Page selection reaches up to 16 Mbytes of extended data space.
// - Only the read page selector reaches the 8-Mbyte program space view.
// - Read page 0x200 or above sends paged reads to program space.
// - Program space is read-only; paged accesses never write it.
// - Write page selector addresses data space only, never program space.
// - Paged reads use the read page, paged writes the write page.
`timescale 1ns/1ps

module paged_data_space_address_gen (
    input  wire logic                             ref_clk,
    input  wire logic                             sys_rst,
    input  wire paged_pkg::core_req_t             core_req,
    input  wire logic                             read_page_load,
    input  wire logic                             write_page_load,
    input  wire logic [paged_pkg::PAGE_W-1:0]     page_value,
    output paged_pkg::mem_req_t                   mem_req,
    output logic [paged_pkg::PAGE_W-1:0]          read_page_select,
    output logic [paged_pkg::PAGE_W-1:0]          write_page_select
);

    paged_pkg::mem_req_t next_mem_req;

    // Read page selector; any 10-bit value, program range included.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            read_page_select <= paged_pkg::READ_PAGE_RST;
        end else if (read_page_load) begin
            read_page_select <= page_value;
        end
    end

    // Write page selector. Program range values are kept but the map
    // drops writes through them, so software sees what it wrote.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            write_page_select <= paged_pkg::WRITE_PAGE_RST;
        end else if (write_page_load) begin
            write_page_select <= page_value;
        end
    end

    page_map u_map (
        .req               (core_req),
        .read_page_select  (read_page_select),
        .write_page_select (write_page_select),
        .mapped            (next_mem_req)
    );

    // One register stage keeps every output straight off a flip-flop.
    // Page loads in the same cycle take effect for the next access only.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mem_req <= '0;
        end else begin
            mem_req <= next_mem_req;
        end
    end

    // Assertion helpers: the request and pages of the previous cycle.
    paged_pkg::core_req_t           prev_req;
    logic [paged_pkg::PAGE_W-1:0]   prev_rd;
    logic [paged_pkg::PAGE_W-1:0]   prev_wr;
    always_ff @(posedge ref_clk) begin
        prev_req <= core_req;
        prev_rd  <= read_page_select;
        prev_wr  <= write_page_select;
    end

    a_no_prog_write: assert property (@(posedge ref_clk) disable iff
        (sys_rst) mem_req.valid && mem_req.write
        |-> mem_req.target != paged_pkg::TGT_PROG)
        else $error("Write was mapped into program space.");

    a_write_page_use: assert property (@(posedge ref_clk) disable iff
        (sys_rst) core_req.valid && core_req.write
        && core_req.addr[paged_pkg::UPPER_BIT]
        && write_page_select < paged_pkg::PROG_PAGE_BASE
        |=> mem_req.valid && mem_req.target == paged_pkg::TGT_EXT_DATA
        && mem_req.addr[paged_pkg::PAGED_W-1:paged_pkg::WIN_OFS_W]
           == prev_wr)
        else $error("Paged write did not use the write page.");

    a_read_page_use: assert property (@(posedge ref_clk) disable iff
        (sys_rst) core_req.valid && !core_req.write
        && core_req.addr[paged_pkg::UPPER_BIT]
        |=> mem_req.addr[paged_pkg::PAGED_W-1:paged_pkg::WIN_OFS_W]
           == prev_rd)
        else $error("Paged read did not use the read page.");

    a_prog_read_map: assert property (@(posedge ref_clk) disable iff
        (sys_rst) core_req.valid && !core_req.write
        && core_req.addr[paged_pkg::UPPER_BIT]
        && read_page_select >= paged_pkg::PROG_PAGE_BASE
        |=> mem_req.target == paged_pkg::TGT_PROG)
        else $error("High read page did not reach program space.");

    a_data_read_map: assert property (@(posedge ref_clk) disable iff
        (sys_rst) core_req.valid && !core_req.write
        && core_req.addr[paged_pkg::UPPER_BIT]
        && read_page_select < paged_pkg::PROG_PAGE_BASE
        |=> mem_req.target == paged_pkg::TGT_EXT_DATA)
        else $error("Low read page left data space.");

    a_base_bypass: assert property (@(posedge ref_clk) disable iff
        (sys_rst) core_req.valid && !core_req.addr[paged_pkg::UPPER_BIT]
        |=> mem_req.valid && mem_req.target == paged_pkg::TGT_BASE_DATA
        && mem_req.addr == {{paged_pkg::PAGE_W{1'b0}},
                            prev_req.addr[paged_pkg::WIN_OFS_W-1:0]})
        else $error("Base access was altered by paging.");

    a_window_offset: assert property (@(posedge ref_clk) disable iff
        (sys_rst) core_req.valid
        |=> mem_req.addr[paged_pkg::WIN_OFS_W-1:0]
            == $past(core_req.addr[paged_pkg::WIN_OFS_W-1:0]))
        else $error("Window offset was not carried through.");

    a_write_dropped: assert property (@(posedge ref_clk) disable iff
        (sys_rst) core_req.valid && core_req.write
        && core_req.addr[paged_pkg::UPPER_BIT]
        && write_page_select >= paged_pkg::PROG_PAGE_BASE
        |=> !mem_req.valid)
        else $error("Write through program page was not dropped.");

    a_page_load: assert property (@(posedge ref_clk) disable iff
        (sys_rst) read_page_load ##1 !read_page_load
        |-> read_page_select == $past(page_value))
        else $error("Read page selector did not load.");

    c_prog_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
        mem_req.valid && mem_req.target == paged_pkg::TGT_PROG);
    c_ext_write: cover property (@(posedge ref_clk) disable iff (sys_rst)
        mem_req.valid && mem_req.write
        && mem_req.target == paged_pkg::TGT_EXT_DATA);
    c_base_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
        mem_req.valid && !mem_req.write
        && mem_req.target == paged_pkg::TGT_BASE_DATA);
    c_drop_write: cover property (@(posedge ref_clk) disable iff (sys_rst)
        mem_req.target == paged_pkg::TGT_NONE);

endmodule : paged_data_space_address_gen

/* File: tb/core_model.sv */
/*
 * Model of the core load/store path that feeds the address generator.
 * Assumes the bench calls its tasks just after a rising edge of ref_clk.
 */
`timescale 1ns/1ps

module core_model (
    output paged_pkg::core_req_t core_req
);
    // Starts idle so the design sees a known request at time zero.
    initial core_req = '0;

    // One access per call; the bench owns the cycle spacing.
    task automatic drive(input logic w, input logic [15:0] a);
        core_req <= '{valid: 1'h1, write: w, addr: a};
    endtask : drive

    // Idle lines show the inverse address so a stale copy never matches.
    task automatic idle();
        core_req <= '{valid: 1'h0, write: 1'h0, addr: ~core_req.addr};
    endtask : idle
endmodule : core_model

/* File: tb/testbench.sv */
/*
 * Self-checking bench for the paged address generator: table of mapped
 * accesses, then refused writes, page load ordering and a second reset.
 * Assumes the design package and core model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module testbench;
    // One access: pages to load, request, expected target and page.
    typedef struct {
        logic [9:0]  rp;
        logic [9:0]  wp;
        logic        wr;
        logic [15:0] a;
        logic [1:0]  t;
        logic [9:0]  pg;
    } row_t;
    logic                          ref_clk = 1'h0;
    logic                          sys_rst = 1'h1;
    logic                          read_page_load = 1'h0;
    logic                          write_page_load = 1'h0;
    logic [9:0]                    page_value = 10'h000;
    paged_pkg::core_req_t          core_req;
    paged_pkg::mem_req_t           mem_req;
    logic [9:0]                    read_page_select;
    logic [9:0]                    write_page_select;
    int                            err_total = 0;
    int                            checked = 0;
    row_t                          rows[8] = '{
        '{10'h001, 10'h001, 1'h0, 16'h1234, 2'h0, 10'h000},
        '{10'h3FF, 10'h3FF, 1'h1, 16'h7ABC, 2'h0, 10'h000},
        '{10'h1FF, 10'h001, 1'h0, 16'hFFFF, 2'h1, 10'h1FF},
        '{10'h200, 10'h001, 1'h0, 16'h8004, 2'h2, 10'h200},
        '{10'h3FF, 10'h001, 1'h0, 16'h8000, 2'h2, 10'h3FF},
        '{10'h001, 10'h1FF, 1'h1, 16'h8001, 2'h1, 10'h1FF},
        '{10'h3FF, 10'h002, 1'h1, 16'h8010, 2'h1, 10'h002},
        '{10'h005, 10'h200, 1'h0, 16'hC020, 2'h1, 10'h005}};

    always #50 ref_clk = ~ref_clk;

    core_model core (.core_req(core_req));

    paged_data_space_address_gen uut (
        .ref_clk           (ref_clk),
        .sys_rst           (sys_rst),
        .core_req          (core_req),
        .read_page_load    (read_page_load),
        .write_page_load   (write_page_load),
        .page_value        (page_value),
        .mem_req           (mem_req),
        .read_page_select  (read_page_select),
        .write_page_select (write_page_select)
    );

    // Loads both selectors on two separate edges.
    task automatic set_pages(input logic [9:0] rp, input logic [9:0] wp);
        @(posedge ref_clk);
        read_page_load <= 1'h1;
        page_value <= rp;
        @(posedge ref_clk);
        read_page_load <= 1'h0;
        write_page_load <= 1'h1;
        page_value <= wp;
        @(posedge ref_clk);
        write_page_load <= 1'h0;
    endtask : set_pages

    // Issues one request and waits until its answer has settled.
    task automatic access(input logic w, input logic [15:0] a);
        @(posedge ref_clk);
        core.drive(w, a);
        @(posedge ref_clk);
        core.idle();
        @(negedge ref_clk);
    endtask : access

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    // Main sequence: reset, table rows, then the awkward cases.
    initial begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("reset mem_req", 29'h0, mem_req)
        `CHK("reset read page", 10'h001, read_page_select)
        @(posedge ref_clk);
        sys_rst <= 1'h0;
        foreach (rows[i]) begin
            set_pages(rows[i].rp, rows[i].wp);
            access(rows[i].wr, rows[i].a);
            `CHK("row", {1'h1, rows[i].wr, rows[i].t, rows[i].pg,
                rows[i].a[14:0]}, mem_req)
        end
        // A write through a program space page must never go out.
        set_pages(10'h005, 10'h200);
        access(1'h1, 16'h8000);
        `CHK("refused valid", 1'h0, mem_req.valid)
        `CHK("refused target", paged_pkg::TGT_NONE, mem_req.target)
        // A load in the request's cycle takes effect one request later.
        @(posedge ref_clk);
        read_page_load <= 1'h1;
        page_value <= 10'h200;
        core.drive(1'h0, 16'h8004);
        @(posedge ref_clk);
        read_page_load <= 1'h0;
        core.drive(1'h0, 16'h8008);
        @(negedge ref_clk);
        `CHK("old page", 29'h12028004, mem_req)
        @(posedge ref_clk);
        core.idle();
        @(negedge ref_clk);
        `CHK("new page", 29'h15000008, mem_req)
        `CHK("read page", 10'h200, read_page_select)
        // A second reset returns both selectors to their start value.
        @(posedge ref_clk);
        sys_rst <= 1'h1;
        @(posedge ref_clk);
        sys_rst <= 1'h0;
        @(negedge ref_clk);
        `CHK("rerun write page", 10'h001, write_page_select)
        `CHK("rerun read page", 10'h001, read_page_select)
        `CHK("rerun mem_req", 29'h0, mem_req)
        end_sim();
    end
endmodule : testbench
